// ===== verilog/uctl_map.svh
// Register map, reset values and frame constants of the serial control block.
// Included by the design modules; holds definitions only.
`ifndef UCTL_MAP_SVH
`define UCTL_MAP_SVH

// =====================================================================
// Register byte offsets
`define UCTL_OFS_CTRL 8'h00
`define UCTL_OFS_STAT 8'h04
`define UCTL_OFS_MASK 8'h08
`define UCTL_OFS_RXD  8'h0c
`define UCTL_OFS_TXD  8'h10
`define UCTL_OFS_EN   8'h14
`define UCTL_OFS_ADDR 8'h18

// =====================================================================
// Reset values and field layout
`define UCTL_CTRL_RST 8'h00
`define UCTL_STAT_W   7
`define UCTL_STAT_RST 7'h00
`define UCTL_MASK_RST 7'h00
`define UCTL_ADDR_RST 16'h0000
`define UCTL_EVT_MASK 7'h7e
`define UCTL_HAS_MASK 7'h01

// =====================================================================
// Timing and frame lengths
`define UCTL_CLK_HZ      40000000
`define UCTL_BAUD        115200
`define UCTL_FRAME_NOPAR 4'ha
`define UCTL_FRAME_PAR   4'hb

`endif

// ===== verilog/uctl_pkg.sv
// Types and the shared parity function of the serial control block.
// Assumes nothing beyond a SystemVerilog compiler.
package uctl_pkg;

   typedef enum logic [1:0] {
      par_none       = 2'b00,
      par_even       = 2'b01,
      par_odd        = 2'b10,
      par_mark_space = 2'b11
   } uctl_par_t;

   typedef enum logic [2:0] {
      addr_soft_each_byte = 3'b000,
      addr_soft_to_buffer = 3'b001,
      addr_hard_each_byte = 3'b010,
      addr_hard_to_buffer = 3'b011,
      addr_filter_off     = 3'b100
   } uctl_addr_t;

   typedef enum logic [1:0] {
      rx_idle  = 2'b00,
      rx_start = 2'b01,
      rx_bits  = 2'b10
   } uctl_rxst_t;

   typedef struct packed {
      uctl_addr_t rx_address_filter_field;
      uctl_par_t  parity_type;
      logic       parity_fixed_value;
      logic       break_request_bit;
      logic       half_duplex_direction_bit;
   } uctl_ctrl_t;

   typedef struct packed {
      logic rx_parity_mark_seen_flag;
      logic rx_address_match_flag;
      logic rx_overrun_flag;
      logic rx_break_flag;
      logic rx_framing_error_flag;
      logic rx_parity_error_flag;
      logic rx_fifo_has_data_flag;
   } uctl_stat_t;

   typedef struct packed {
      logic [7:0] data;
      logic       par_bit;
      logic       par_err;
      logic       stop_err;
      logic       brk;
   } uctl_rxres_t;

   function automatic logic uctl_par_bit(uctl_par_t t, logic fixed, logic [7:0] d);
      unique case (t)
         par_even:       return ^d;
         par_odd:        return ~^d;
         par_mark_space: return fixed;
         par_none:       return 1'b0;
      endcase
   endfunction

endpackage

// ===== verilog/uctl_tx.sv
// Frame transmitter: start bit, eight data bits LSB first, optional parity, one stop bit.
// Assumes start is a one-cycle request from the same clock, taken only when idle.
`include "uctl_map.svh"
module uctl_tx
   import uctl_pkg::*;
#(
   parameter int BIT_CYCLES = 347
)
(
   // Clock and control
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       go,
   // Frame request
   input  wire logic       start,
   input  wire logic [7:0] data,
   input  wire uctl_par_t  par_type,
   input  wire logic       fixed,
   // Line side
   output logic            busy,
   output logic            line
);

   localparam logic [15:0] LAST = 16'(BIT_CYCLES - 1);

   logic [10:0] sh_q;
   logic [3:0]  left_q;
   logic [15:0] cnt_q;

   assign busy = (left_q != 4'h0);
   assign line = busy ? sh_q[0] : 1'b1;

   always_ff @(posedge clk)
   begin
      if (rst || !go)
      begin
         left_q <= 4'h0;
         cnt_q  <= 16'h0;
         sh_q   <= 11'h7ff;
      end
      else if (ce)
      begin
         if (!busy)
         begin
            if (start)
            begin
               // Parity kind and fixed value are sampled here, so they apply to the next frame.
               // Without parity the stop bit follows the last data bit directly.
               if (par_type == par_none)
                  sh_q <= {2'b11, data, 1'b0};
               else
                  sh_q <= {1'b1, uctl_par_bit(par_type, fixed, data), data, 1'b0};
               left_q <= (par_type == par_none) ? `UCTL_FRAME_NOPAR : `UCTL_FRAME_PAR;
               cnt_q  <= 16'h0;
            end
         end
         else if (cnt_q == LAST)
         begin
            cnt_q  <= 16'h0;
            sh_q   <= {1'b1, sh_q[10:1]};
            left_q <= left_q - 4'h1;
         end
         else
            cnt_q <= cnt_q + 16'h1;
      end
   end

endmodule

// ===== verilog/uctl_rx.sv
// Frame receiver sampling each bit at its middle; reports one result per frame.
// Assumes rxd is already synchronised to clk.
`include "uctl_map.svh"
module uctl_rx
   import uctl_pkg::*;
#(
   parameter int BIT_CYCLES = 347
)
(
   // Clock and control
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  ce,
   input  wire logic  go,
   input  wire logic  rxd,
   input  wire uctl_par_t par_type,
   // Result, done is a one-cycle pulse
   output logic        done,
   output uctl_rxres_t res
);

   localparam logic [15:0] LAST = 16'(BIT_CYCLES - 1);
   localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2);

   uctl_rxst_t  st_q;
   logic [15:0] cnt_q;
   logic [3:0]  left_q;
   logic [9:0]  sh_q;
   logic        armed_q;
   logic [9:0]  nx;
   logic        has_par;
   logic [7:0]  nd;
   logic        np;

   assign nx      = {rxd, sh_q[9:1]};
   assign has_par = (par_type != par_none);
   assign nd      = has_par ? nx[7:0] : nx[8:1];
   assign np      = has_par & nx[8];

   always_ff @(posedge clk)
   begin
      if (rst || !go)
      begin
         st_q <= rx_idle; cnt_q <= 16'h0; left_q <= 4'h0;
         sh_q <= 10'h0; armed_q <= 1'b0; done <= 1'b0; res <= '0;
      end
      else if (ce)
      begin
         done <= 1'b0;
         unique case (st_q)
            rx_idle:
            begin
               // A line held low after a break does not start a new frame.
               armed_q <= rxd;
               if (armed_q && !rxd)
               begin
                  st_q <= rx_start; cnt_q <= 16'h0;
               end
            end
            rx_start:
               if (cnt_q == HALF)
               begin
                  st_q   <= rxd ? rx_idle : rx_bits; cnt_q <= 16'h0;
                  left_q <= (has_par ? `UCTL_FRAME_PAR : `UCTL_FRAME_NOPAR) - 4'h1;
               end
               else
                  cnt_q <= cnt_q + 16'h1;
            rx_bits:
               if (cnt_q == LAST)
               begin
                  cnt_q <= 16'h0; sh_q <= nx; left_q <= left_q - 4'h1;
                  if (left_q == 4'h1)
                  begin
                     st_q <= rx_idle; armed_q <= 1'b0; done <= 1'b1;
                     res.data     <= nd;
                     res.par_bit  <= np;
                     res.par_err  <= (par_type == par_even || par_type == par_odd)
                                     && (np != uctl_par_bit(par_type, 1'b0, nd));
                     res.stop_err <= !rxd;
                     res.brk      <= !rxd && (nd == 8'h00) && !np;
                  end
               end
               else
                  cnt_q <= cnt_q + 16'h1;
            default:
               st_q <= rx_idle;
         endcase
      end
   end

endmodule

// ===== verilog/uctl_serial_ctrl.sv
// Top of the serial control block: AHB-Lite registers, receive status,
// interrupt, address filter, half-duplex direction and break control.
// Assumes one 40 MHz clock, a synchronous reset and one AHB-Lite master.
// What this block does
// - Direction bit 0 receives, 1 transmits.
// - Break request bit puts break on line.
// - Mark/space mode sends the fixed parity value.
// - Two-bit field picks none/even/odd/mark-space parity.
// - Three-bit field picks receiver address handling.
// - Control register is eight bits, written whole.
// - Control read returns all fields as held.
// - Interrupt mask shares receive status layout.
// - Seven receive events are selectable interrupt sources.
// - Block enable low halts transmit and receive.
// - Status read clears events; data read clears has-data.
// - Stop bit sampled low flags framing error.
`include "uctl_map.svh"
module uctl_serial_ctrl
   import uctl_pkg::*;
#(
   parameter int BAUD_RATE   = `UCTL_BAUD,
   parameter bit HALF_DUPLEX = 1'b1
)
(
   // Clock, reset and freeze
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Serial line
   input  wire logic        rx_line,
   output logic             tx_line,
   output logic             tx_drive,
   // Interrupt
   output logic             irq
);

   localparam int BIT_CYCLES = `UCTL_CLK_HZ / BAUD_RATE;

   // =====================================================================
   // Declarations

   uctl_ctrl_t  ctrl_q;
   uctl_ctrl_t  ctrl_d;
   uctl_stat_t  status_q;
   uctl_stat_t  status_d;
   uctl_stat_t  mask_q;
   uctl_stat_t  mask_d;
   uctl_stat_t  ev;
   uctl_rxres_t rx_res;
   logic        en_q;
   logic        en_d;
   logic [15:0] addr_q;
   logic [15:0] addr_d;
   logic [7:0]  rxbuf_q;
   logic        listen_q;
   logic        wr_pend_q;
   logic [7:0]  wa_q;
   logic [31:0] hrdata_q;
   logic        hrdyo_q;
   logic        irq_q;
   logic        tx_line_q;
   logic        tx_drive_q;
   logic        rx_s1_q;
   logic        rx_s2_q;

   logic        acc;
   logic        rd_go;
   logic [7:0]  ra;
   logic        rd_stat;
   logic        rd_rxd;
   logic        wr_ctrl;
   logic        wr_stat;
   logic        wr_mask;
   logic        wr_txd;
   logic        wr_en;
   logic        wr_addr;
   logic [31:0] rd_word;
   logic [`UCTL_STAT_W-1:0] clr;

   logic        tx_go;
   logic        rx_go;
   logic        tx_start;
   logic        tx_busy;
   logic        tx_bit;
   logic        rx_done;
   logic        is_addr;
   logic        hit;
   logic        hw_mode;
   logic        store;
   logic        ev_ovr;

   // =====================================================================
   // Bus decode

   assign acc     = hsel && htrans[1] && hready;
   assign rd_go   = acc && !hwrite;
   assign ra      = haddr[7:0];
   assign rd_stat = rd_go && (ra == `UCTL_OFS_STAT);
   assign rd_rxd  = rd_go && (ra == `UCTL_OFS_RXD);
   assign wr_ctrl = wr_pend_q && (wa_q == `UCTL_OFS_CTRL);
   assign wr_stat = wr_pend_q && (wa_q == `UCTL_OFS_STAT);
   assign wr_mask = wr_pend_q && (wa_q == `UCTL_OFS_MASK);
   assign wr_txd  = wr_pend_q && (wa_q == `UCTL_OFS_TXD);
   assign wr_en   = wr_pend_q && (wa_q == `UCTL_OFS_EN);
   assign wr_addr = wr_pend_q && (wa_q == `UCTL_OFS_ADDR);

   // =====================================================================
   // Register next values

   // The whole byte is replaced in one write; there is no per-field access.
   assign ctrl_d = wr_ctrl ? uctl_ctrl_t'(hwdata[7:0]) : ctrl_q;
   assign mask_d = wr_mask ? uctl_stat_t'(hwdata[`UCTL_STAT_W-1:0]) : mask_q;
   assign en_d   = wr_en ? hwdata[0] : en_q;
   assign addr_d = wr_addr ? hwdata[15:0] : addr_q;

   // Control, mask, enable and address reads see the value a write in the same edge installs, so a read
   // straight after a write returns the new control byte.
   assign rd_word =
      (ra == `UCTL_OFS_CTRL) ? {24'h0, ctrl_d} :
      (ra == `UCTL_OFS_STAT) ? {25'h0, status_q} :
      (ra == `UCTL_OFS_MASK) ? {25'h0, mask_d} :
      (ra == `UCTL_OFS_RXD)  ? {24'h0, rxbuf_q} :
      (ra == `UCTL_OFS_EN)   ? {30'h0, tx_busy, en_d} :
      (ra == `UCTL_OFS_ADDR) ? {16'h0, addr_d} :
      32'h0;

   // =====================================================================
   // Direction, enable and line control

   assign tx_go    = en_q && (!HALF_DUPLEX || ctrl_q.half_duplex_direction_bit);
   assign rx_go    = en_q && !(HALF_DUPLEX && ctrl_q.half_duplex_direction_bit);
   // A data write while a frame is in flight is dropped; software polls busy.
   assign tx_start = wr_txd && tx_go && !tx_busy;

   uctl_tx #(
      .BIT_CYCLES (BIT_CYCLES)
   ) u_tx (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .go       (tx_go),
      .start    (tx_start),
      .data     (hwdata[7:0]),
      .par_type (ctrl_q.parity_type),
      .fixed    (ctrl_q.parity_fixed_value),
      .busy     (tx_busy),
      .line     (tx_bit)
   );

   uctl_rx #(
      .BIT_CYCLES (BIT_CYCLES)
   ) u_rx (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .go       (rx_go),
      .rxd      (rx_s2_q),
      .par_type (ctrl_q.parity_type),
      .done     (rx_done),
      .res      (rx_res)
   );

   // =====================================================================
   // Address filter and receive events

   // In mark/space mode a set ninth bit marks an address byte.
   assign is_addr = (ctrl_q.parity_type == par_mark_space) && rx_res.par_bit;
   assign hit     = (rx_res.data == addr_q[7:0]) || (rx_res.data == addr_q[15:8]);
   assign hw_mode = (ctrl_q.rx_address_filter_field == addr_hard_each_byte) ||
                    (ctrl_q.rx_address_filter_field == addr_hard_to_buffer);

   // Software modes hand every byte up and leave the decision to firmware.
   assign store = rx_done &&
                  ((ctrl_q.rx_address_filter_field != addr_hard_to_buffer) ||
                   (!is_addr && listen_q));

   // An unread byte is kept; the newcomer is lost and flagged.
   assign ev_ovr = store && status_q.rx_fifo_has_data_flag && !rd_rxd;

   assign ev = {rx_done && is_addr &&
                (ctrl_q.rx_address_filter_field != addr_filter_off),
                rx_done && is_addr && hw_mode && hit,
                ev_ovr,
                rx_done && rx_res.brk,
                rx_done && rx_res.stop_err,
                rx_done && rx_res.par_err,
                store};

   // =====================================================================
   // Status clearing and interrupt

   assign clr = (rd_stat ? `UCTL_EVT_MASK : `UCTL_STAT_RST) |
                (wr_stat ? hwdata[`UCTL_STAT_W-1:0] : `UCTL_STAT_RST) |
                (rd_rxd ? `UCTL_HAS_MASK : `UCTL_STAT_RST);

   // New events win over a clear in the same cycle.
   assign status_d = uctl_stat_t'(ev | (status_q & ~clr));

   // =====================================================================
   // Registers

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_q   <= uctl_ctrl_t'(`UCTL_CTRL_RST);
         mask_q   <= uctl_stat_t'(`UCTL_MASK_RST);
         status_q <= uctl_stat_t'(`UCTL_STAT_RST);
         en_q     <= 1'b0;
         addr_q   <= `UCTL_ADDR_RST;
      end
      else if (ce)
      begin
         ctrl_q   <= ctrl_d;
         mask_q   <= mask_d;
         status_q <= status_d;
         en_q     <= en_d;
         addr_q   <= addr_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rxbuf_q  <= 8'h00;
         listen_q <= 1'b0;
      end
      else if (ce)
      begin
         if (store && !ev_ovr)
            rxbuf_q <= rx_res.data;
         if (rx_done && is_addr)
            listen_q <= hit;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_pend_q <= 1'b0;
         wa_q      <= 8'h00;
         hrdata_q  <= 32'h0;
         hrdyo_q   <= 1'b1;
      end
      else if (ce)
      begin
         wr_pend_q <= acc && hwrite;
         wa_q      <= ra;
         hrdyo_q   <= 1'b1;
         if (rd_go)
            hrdata_q <= rd_word;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_q      <= 1'b0;
         tx_line_q  <= 1'b1;
         tx_drive_q <= 1'b0;
         rx_s1_q    <= 1'b1;
         rx_s2_q    <= 1'b1;
      end
      else if (ce)
      begin
         irq_q      <= |(status_d & mask_d);
         tx_line_q  <= ctrl_d.break_request_bit ? 1'b0 : tx_bit;
         tx_drive_q <= tx_go;
         rx_s1_q    <= rx_line;
         rx_s2_q    <= rx_s1_q;
      end
   end

   assign hreadyout = hrdyo_q;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign tx_line   = tx_line_q;
   assign tx_drive  = tx_drive_q;
   assign irq       = irq_q;

   // =====================================================================
   // Checks

   default clocking cb @(posedge clk);
   endclocking

   default disable iff (rst);

   sequence s_ctrl_wr;
      ce && acc && hwrite && (ra == `UCTL_OFS_CTRL) ##1 ce;
   endsequence

   chk_ctrl_write_whole: assert property (
      s_ctrl_wr |=> (ctrl_q == $past(hwdata[7:0])))
      else $error("control byte not taken whole");

   chk_ctrl_read_back: assert property (
      (ce && rd_go && (ra == `UCTL_OFS_CTRL)) |=> (hrdata_q == {24'h0, ctrl_q}))
      else $error("control read differs from held value");

   chk_break_space: assert property (
      (ce && ctrl_q.break_request_bit) [*2] |-> !tx_line_q)
      else $error("line not at space during break");

   chk_rx_dir_block: assert property (
      (HALF_DUPLEX && ctrl_q.half_duplex_direction_bit) [*2] |-> !rx_done)
      else $error("receiver active in transmit direction");

   chk_tx_dir_block: assert property (
      (HALF_DUPLEX && !ctrl_q.half_duplex_direction_bit) [*2] |-> !tx_busy)
      else $error("transmitter active in receive direction");

   chk_disable_halt: assert property (
      (!en_q && !$past(en_q)) |-> (!tx_busy && !rx_done))
      else $error("transfer while disabled");

   chk_irq_gate_mask: assert property (
      irq == |(status_q & mask_q))
      else $error("interrupt not status and mask");

   chk_status_clear_rd: assert property (
      (ce && rd_stat && !rx_done) |=> (status_q[6:1] == 6'h00))
      else $error("status read left event bits set");

   chk_frame_err_flag: assert property (
      (ce && rx_done && rx_res.stop_err) |=> status_q.rx_framing_error_flag)
      else $error("framing error not flagged");

   chk_has_data_set: assert property (
      (ce && store) |=> status_q.rx_fifo_has_data_flag)
      else $error("stored byte not flagged");

endmodule

// ===== sim/uctl_remote_node.sv
// Remote serial node: sends frames into the block's receive pin and captures
// frames from its transmit pin.
// Assumes the block's clock and a bit time of BIT_CYCLES clock cycles.
module uctl_remote_node
#(
   parameter int BIT_CYCLES = 10
)
(
   // Clock
   input  wire logic clk,
   // Line side
   input  wire logic tx_line,
   output logic      rx_line
);
   timeunit 1ns;
   timeprecision 100ps;

   // The line rests at the mark level between frames, as a biased line does.
   initial rx_line = 1'b1;

   // =====================================================================
   // Frame sender; the stop level and parity value are the caller's choice
   // so that faulty frames can be made on purpose.
   task automatic send(input logic [7:0] d, input logic pen, input logic pv, input logic st);
      logic [10:0] f;
      int          n;
      f = pen ? {st, pv, d, 1'b0} : {1'b1, st, d, 1'b0};
      n = pen ? 11 : 10;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         rx_line <= f[i];
         repeat (BIT_CYCLES - 1) @(posedge clk);
      end
      @(posedge clk);
      rx_line <= 1'b1;
   endtask

   // =====================================================================
   // Frame capture: ten bits after the start bit, each at its middle.
   task automatic recv(output logic [9:0] bits);
      int n;
      n = 0;
      while (tx_line !== 1'b0 && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 10; i++)
      begin
         repeat (BIT_CYCLES) @(posedge clk);
         bits[i] = tx_line;
      end
   endtask
endmodule

// ===== sim/tb_uctl_serial_ctrl.sv
// Self-checking bench of the serial control block: registers, transmit
// frames, receive status, interrupt, direction, break and enable.
// Assumes the remote node model and ten clock cycles per bit.
`include "uctl_map.svh"
module tb_uctl_serial_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BIT = 10;

   logic        clk, rst, ce, hsel, hwrite, hready, hreadyout, hresp;
   logic        rx_line, tx_line, tx_drive, irq, pb;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  d;
   logic [9:0]  fr, ef;
   int          error_cnt, comparisons, seed, cyc, v;

   assign hready = hreadyout;

   uctl_serial_ctrl #(.BAUD_RATE(4000000), .HALF_DUPLEX(1'b1)) dut_u (
      .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_line(rx_line),
      .tx_line(tx_line), .tx_drive(tx_drive), .irq(irq));

   uctl_remote_node #(.BIT_CYCLES(BIT)) node_u (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // The whole run needs some 2700 cycles; the ceiling leaves ample margin.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end

   // =====================================================================
   // Checking and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic test_done();
      $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // =====================================================================
   // Receive model: status events expected for one or more frames.
   function automatic logic [6:0] exp_ev(input logic [7:0] c, input logic [7:0] dd,
                                         input logic pv, input logic st, input int n);
      logic [6:0] e;
      // Hardware detect-to-buffer mode keeps address bytes out of the buffer.
      e[0] = !(c[7:3] == 5'h0f && pv);
      if (c[4:3] == 2'd1 || c[4:3] == 2'd2)
         e[1] = (^dd ^ pv) ^ (c[4:3] == 2'd2);
      else
         e[1] = 1'b0;
      e[2] = !st;
      e[3] = !st && dd == 8'h00 && (c[4:3] == 2'd0 || !pv);
      e[4] = n > 1;
      e[6] = c[4:3] == 2'd3 && pv && c[7:5] != 3'd4;
      e[5] = e[6] && (c[7:5] == 3'd2 || c[7:5] == 3'd3) && dd == 8'h5a;
      return e;
   endfunction

   task automatic rx_case(input logic [7:0] c, input logic [7:0] dd, input logic pv,
                          input logic st, input int n, input logic [6:0] cm);
      logic [6:0] e;
      e = exp_ev(c, dd, pv, st, n) & cm;
      bus(1'b1, `UCTL_OFS_CTRL, {24'h0, c});
      bus(1'b1, `UCTL_OFS_STAT, 32'h7f);
      bus(1'b0, `UCTL_OFS_RXD, 32'h0);
      repeat (n) node_u.send(dd, c[4:3] != 2'd0, pv, st);
      repeat (BIT * 2) @(posedge clk);
      bus(1'b1, `UCTL_OFS_MASK, {25'h0, e});
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, {31'h0, |e});
      bus(1'b1, `UCTL_OFS_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(`UCTL_OFS_STAT, {25'h0, exp_ev(c, dd, pv, st, n)});
      chk(rd & {25'h0, cm}, {25'h0, e});
      bus(1'b0, `UCTL_OFS_STAT, 32'h0);
      chk(rd & 32'h7e, 32'h0);
      if (cm[0])
      begin
         rdchk(`UCTL_OFS_RXD, {24'h0, dd});
         rdchk(`UCTL_OFS_STAT, 32'h0);
      end
      $display("test rx %h done", c);
   endtask

   // =====================================================================
   // Main sequence
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      seed = 67;
      cyc = 0;
      error_cnt = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdchk(`UCTL_OFS_CTRL, 32'h0);
      rdchk(`UCTL_OFS_STAT, 32'h0);
      rdchk(`UCTL_OFS_MASK, 32'h0);
      rdchk(8'h1c, 32'h0);
      chk({30'h0, tx_line, tx_drive}, 32'h2);
      for (int i = 0; i < 8; i++)
      begin
         v = ($random(seed) & 7) | ((i % 4) << 3) | ((i % 5) << 5);
         bus(1'b1, `UCTL_OFS_CTRL, v);
         rdchk(`UCTL_OFS_CTRL, v);
      end
      $display("test control done");
      bus(1'b1, `UCTL_OFS_EN, 32'h1);
      bus(1'b1, `UCTL_OFS_CTRL, 32'h80);
      bus(1'b1, `UCTL_OFS_TXD, 32'h55);
      repeat (5) @(posedge clk);
      chk({30'h0, tx_line, tx_drive}, 32'h2);
      bus(1'b1, `UCTL_OFS_CTRL, 32'h81);
      repeat (3) @(posedge clk);
      chk({31'h0, tx_drive}, 32'h1);
      bus(1'b1, `UCTL_OFS_EN, 32'h0);
      bus(1'b1, `UCTL_OFS_TXD, 32'h00);
      repeat (5) @(posedge clk);
      chk({30'h0, tx_line, tx_drive}, 32'h2);
      bus(1'b1, `UCTL_OFS_EN, 32'h1);
      bus(1'b1, `UCTL_OFS_CTRL, 32'h83);
      repeat (3) @(posedge clk);
      chk({31'h0, tx_line}, 32'h0);
      repeat (BIT * 12) @(posedge clk);
      chk({31'h0, tx_line}, 32'h0);
      bus(1'b1, `UCTL_OFS_CTRL, 32'h81);
      repeat (3) @(posedge clk);
      chk({31'h0, tx_line}, 32'h1);
      $display("test direction and break done");
      for (int p = 0; p < 5; p++)
      begin
         d = 8'($random(seed));
         v = 32'h81 | ((p > 3 ? 3 : p) << 3) | ((p == 3) << 2);
         bus(1'b1, `UCTL_OFS_CTRL, v);
         fork
            node_u.recv(fr);
            bus(1'b1, `UCTL_OFS_TXD, {24'h0, d});
         join
         pb = (p == 1) ? ^d : (p == 2) ? ~^d : (p == 3);
         ef = (p == 0) ? {2'b11, d} : {1'b1, pb, d};
         chk({22'h0, fr}, {22'h0, ef});
         repeat (BIT * 2) @(posedge clk);
      end
      $display("test transmit parity done");
      bus(1'b1, `UCTL_OFS_ADDR, 32'h5a);
      d = 8'($random(seed));
      rx_case(8'h80, d, 1'b0, 1'b1, 1, 7'h7f);
      rx_case(8'h88, 8'h03, 1'b1, 1'b1, 1, 7'h7e);
      rx_case(8'h90, 8'h03, 1'b1, 1'b1, 1, 7'h7f);
      rx_case(8'h80, 8'ha5, 1'b0, 1'b0, 1, 7'h7e);
      rx_case(8'h80, 8'h00, 1'b0, 1'b0, 1, 7'h7e);
      rx_case(8'h80, d, 1'b0, 1'b1, 2, 7'h7f);
      rx_case(8'h58, 8'h5a, 1'b1, 1'b1, 1, 7'h7e);
      rx_case(8'h18, 8'h21, 1'b1, 1'b1, 1, 7'h7e);
      rx_case(8'h98, 8'h21, 1'b1, 1'b1, 1, 7'h7e);
      // A matching address opens the buffer for the data byte that follows.
      rx_case(8'h78, 8'h5a, 1'b1, 1'b1, 1, 7'h7e);
      rx_case(8'h78, 8'h33, 1'b0, 1'b1, 1, 7'h7f);
      test_done();
   end
endmodule
